//--- common/vcc_pkg.sv
package vcc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices of the capability words
    localparam logic [11:0] EXIT_CAP_IDX      = 12'h483;
    localparam logic [11:0] ENTRY_CAP_IDX     = 12'h484;
    localparam logic [11:0] SEC_CAP_IDX       = 12'h48B;
    localparam logic [11:0] FULL_EXIT_CAP_IDX = 12'h48F;
    localparam logic [11:0] FULL_ENTRY_CAP_IDX = 12'h490;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned HIGH_HALF_LSB     = 32;
    localparam int unsigned FULL_WORD_SEL_BIT = 55;
    localparam int unsigned SEC_GATE_CAP_BIT  = 63;
    localparam int unsigned SEC_GATE_CTL_BIT  = 31;

    // Forced-one class masks (bits 0-8,10,11,13,14,16,17 and bits 0-8,12)
    localparam logic [31:0] EXIT_FORCED_ONE_MASK  = 32'h0003_6DFF;
    localparam logic [31:0] ENTRY_FORCED_ONE_MASK = 32'h0000_11FF;

    ////////////////////////////////////////////////////////////////////////////////
    // Implementation values of the capability words (plain defaults)
    localparam logic [63:0] BASIC_CAP_RST      = 64'h0080_0000_0000_0000;
    localparam logic [63:0] PRIMARY_CAP_RST    = 64'hFFFF_FFFF_0401_E172;
    localparam logic [63:0] SEC_CAP_RST        = 64'h0000_00FF_0000_0000;
    localparam logic [63:0] EXIT_CAP_RST       = 64'h003F_FFFF_0003_6DFF;
    localparam logic [63:0] ENTRY_CAP_RST      = 64'h0000_FFFF_0000_11FF;
    localparam logic [63:0] FULL_EXIT_CAP_RST  = 64'h003F_FFFF_0003_6DFB;
    localparam logic [63:0] FULL_ENTRY_CAP_RST = 64'h0000_FFFF_0000_11FB;

    // Requested control set presented at entry
    typedef struct packed {
        logic [31:0] primary;
        logic [31:0] secondary;
        logic [31:0] exit_ctl;
        logic [31:0] entry_ctl;
    } vcc_ctl_s;

    // Per-word failure causes
    typedef struct packed {
        logic sec_fail;
        logic exit_fail;
        logic entry_fail;
    } vcc_fail_s;

endpackage

//--- rtl/vcc_word_check.sv
`timescale 1ns/1ps
// Checks one control word against one 64-bit capability word
module vcc_word_check
    import vcc_pkg::*;
(
    input  wire logic [31:0] ctl_i,   // Requested controls
    input  wire logic [63:0] cap_i,   // Capability word in effect
    input  wire logic        gate_i,  // High enables the allowed-1 check
    output logic             fail_o   // Entry would fail
);
    // Low half: required ones; high half: permitted ones
    assign fail_o = (|(~ctl_i & cap_i[31:0])) | (gate_i & (|(ctl_i & ~cap_i[63:32])));
endmodule

//--- rtl/vcc_cap_check.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Secondary low half reads zero; zeros accepted.
// - Secondary one refused only when gate set.
// - Secondary word exists only if gate allowed.
// - Exit controls checked against both halves.
// - Exit forced-one low bits read one.
// - Legacy mode: exit forced-one zero fails.
// - Full mode: full exit word frees bit 2 only.
// - Full exit word covers all exit controls.
// - Entry control zero fails if required.
// - Entry forced-one low bits read one.
// - Legacy mode: entry forced-one zero fails.
// - Entry control one needs permission bit.
// - Full mode: full entry word frees bit 2 only.
// - Full entry low half covers all.
module vcc_cap_check
    import vcc_pkg::*;
(
    input  wire logic             mclk_i,     // 20 MHz clock
    input  wire logic             rstn_i,     // Async reset, active low
    input  wire logic             rd_en_i,    // Capability read strobe
    input  wire logic [11:0]      rd_idx_i,   // Capability index
    input  wire logic             wr_en_i,    // Write strobe, ignored
    input  wire logic [63:0]      wr_data_i,  // Write data, ignored
    output logic [63:0]           rd_data_o,  // Registered read data
    output logic                  rd_valid_o, // Read data valid pulse
    output logic                  rd_err_o,   // Unimplemented index pulse
    input  wire logic             chk_i,      // Entry check request
    input  wire vcc_pkg::vcc_ctl_s ctl_i,     // Requested controls
    output logic                  fail_o,     // Combinational entry verdict
    output vcc_pkg::vcc_fail_s    cause_o,    // Registered failure causes
    output logic                  done_o      // Check result pulse
);
    import vcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Constant capability words; no flops hold them, so writes cannot alter them
    logic [63:0] exit_cap;       // Legacy exit word
    logic [63:0] entry_cap;      // Legacy entry word
    logic        full_mode;      // Bit 55 of basic word
    logic        sec_present;    // Secondary word implemented
    logic        gate;           // Secondary gate requested

    assign full_mode   = BASIC_CAP_RST[FULL_WORD_SEL_BIT];
    assign sec_present = PRIMARY_CAP_RST[SEC_GATE_CAP_BIT];
    assign exit_cap    = EXIT_CAP_RST | {32'h0000_0000, EXIT_FORCED_ONE_MASK};
    assign entry_cap   = ENTRY_CAP_RST | {32'h0000_0000, ENTRY_FORCED_ONE_MASK};
    assign gate        = ctl_i.primary[SEC_GATE_CTL_BIT];

    // Returns the word held at an index, and whether it exists
    function automatic logic [64:0] cap_lookup(input logic [11:0] idx);
        logic [64:0] r;
        r = 65'h0;
        case (idx)
            EXIT_CAP_IDX:       r = {1'b1, exit_cap};
            ENTRY_CAP_IDX:      r = {1'b1, entry_cap};
            SEC_CAP_IDX:        r = {sec_present, SEC_CAP_RST[63:32], 32'h0000_0000};
            FULL_EXIT_CAP_IDX:  r = {full_mode, FULL_EXIT_CAP_RST};
            FULL_ENTRY_CAP_IDX: r = {full_mode, FULL_ENTRY_CAP_RST};
            default:            r = 65'h0;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Read port; an absent word reads zero and raises the error pulse
    logic [64:0] look;   // Lookup result
    assign look = cap_lookup(rd_idx_i);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_data_o  <= 64'h0;
            rd_valid_o <= 1'b0;
            rd_err_o   <= 1'b0;
        end else begin
            // Writes are dropped on purpose: the words are fixed
            rd_valid_o <= rd_en_i;
            rd_err_o   <= rd_en_i & ~look[64];
            if (rd_en_i) begin
                rd_data_o <= look[64] ? look[63:0] : 64'h0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Word selection by bit 55 (exit, entry); secondary word by bit 63 of primary word
    logic [63:0] exit_eff;   // Exit word in effect
    logic [63:0] entry_eff;  // Entry word in effect
    logic [63:0] sec_eff;    // Secondary word in effect

    assign exit_eff  = full_mode ? FULL_EXIT_CAP_RST  : exit_cap;
    assign entry_eff = full_mode ? FULL_ENTRY_CAP_RST : entry_cap;
    // Without the secondary word, no secondary one is permitted
    assign sec_eff   = sec_present ? {SEC_CAP_RST[63:32], 32'h0000_0000} : 64'h0;

    vcc_fail_s fail_c;      // Combinational causes
    logic      sec_fail;    // Secondary word verdict
    logic      exit_fail;   // Exit word verdict
    logic      entry_fail;  // Entry word verdict

    vcc_word_check u_sec (
        .ctl_i  (ctl_i.secondary),
        .cap_i  (sec_eff),
        .gate_i (gate),
        .fail_o (sec_fail)
    );
    vcc_word_check u_exit (
        .ctl_i  (ctl_i.exit_ctl),
        .cap_i  (exit_eff),
        .gate_i (1'b1),
        .fail_o (exit_fail)
    );
    vcc_word_check u_entry (
        .ctl_i  (ctl_i.entry_ctl),
        .cap_i  (entry_eff),
        .gate_i (1'b1),
        .fail_o (entry_fail)
    );

    // One driver for the whole struct keeps strict tools content
    assign fail_c = '{sec_fail: sec_fail, exit_fail: exit_fail, entry_fail: entry_fail};

    assign fail_o = |fail_c;

    ////////////////////////////////////////////////////////////////////////////////
    // Registered verdict, one cycle after the request
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cause_o <= '0;
            done_o  <= 1'b0;
        end else begin
            done_o <= chk_i;
            if (chk_i) begin
                cause_o <= fail_c;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions
    a_sec_low_zero: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        rd_en_i && rd_idx_i == SEC_CAP_IDX |=> rd_data_o[31:0] == 32'h0)
        else $error("secondary low half not zero");
    a_sec_gate_off: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !gate |-> !fail_c.sec_fail)
        else $error("secondary failed with gate clear");
    a_exit_forced: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        rd_en_i && rd_idx_i == EXIT_CAP_IDX |=> (rd_data_o[31:0] & EXIT_FORCED_ONE_MASK) == EXIT_FORCED_ONE_MASK)
        else $error("exit forced-one bits not one");
    a_entry_forced: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        rd_en_i && rd_idx_i == ENTRY_CAP_IDX |=> (rd_data_o[31:0] & ENTRY_FORCED_ONE_MASK) == ENTRY_FORCED_ONE_MASK)
        else $error("entry forced-one bits not one");
    a_exit_legacy: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !full_mode && ((ctl_i.exit_ctl & EXIT_FORCED_ONE_MASK) != EXIT_FORCED_ONE_MASK) |-> fail_o)
        else $error("exit forced-one zero accepted");
    a_entry_legacy: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        !full_mode && ((ctl_i.entry_ctl & ENTRY_FORCED_ONE_MASK) != ENTRY_FORCED_ONE_MASK) |-> fail_o)
        else $error("entry forced-one zero accepted");
    a_entry_one: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        |(ctl_i.entry_ctl & ~entry_eff[63:32]) |-> fail_c.entry_fail)
        else $error("entry one without permission accepted");
    a_verdict_held: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        chk_i |=> done_o && cause_o.exit_fail == $past(fail_c.exit_fail))
        else $error("exit verdict not registered");
    a_word_fixed: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        wr_en_i ##1 rd_en_i && rd_idx_i == FULL_EXIT_CAP_IDX && full_mode |=> rd_data_o == FULL_EXIT_CAP_RST)
        else $error("capability word changed");
endmodule

//--- dv/virt_control_capability_check_tb.sv
`timescale 1ns/1ps
module virt_control_capability_check_tb;
    import vcc_pkg::*;
    logic        mclk_i, rstn_i, rd_en_i, wr_en_i, chk_i, rd_valid_o, rd_err_o, fail_o, done_o;
    logic [11:0] rd_idx_i;                         // Capability index
    logic [63:0] wr_data_i, rd_data_o;             // Write and read words
    vcc_ctl_s    ctl_i, base;                      // Requested controls and a legal set
    vcc_fail_s   cause_o;                          // Captured causes
    int          err_total = 0, n_tests = 0;       // Mismatch and compare counts

    vcc_cap_check dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .rd_en_i(rd_en_i), .rd_idx_i(rd_idx_i),
        .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
        .rd_err_o(rd_err_o), .chk_i(chk_i), .ctl_i(ctl_i), .fail_o(fail_o), .cause_o(cause_o), .done_o(done_o));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock; 50 ns period
    initial begin
        mclk_i = 1'b0;
        forever #25 mclk_i = ~mclk_i;
    end

    // Single compare point; four-state so unknowns never match
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Reference verdict {sec, exit, entry}; legacy words get forced-one bits when bit 55 is clear
    function automatic logic [2:0] ref_fail(input vcc_ctl_s c);
        logic [63:0] xc, nc;
        xc = BASIC_CAP_RST[FULL_WORD_SEL_BIT] ? FULL_EXIT_CAP_RST : (EXIT_CAP_RST | {32'h0, EXIT_FORCED_ONE_MASK});
        nc = BASIC_CAP_RST[FULL_WORD_SEL_BIT] ? FULL_ENTRY_CAP_RST : (ENTRY_CAP_RST | {32'h0, ENTRY_FORCED_ONE_MASK});
        ref_fail[2] = c.primary[SEC_GATE_CTL_BIT] & (|(c.secondary & ~SEC_CAP_RST[63:32]));
        ref_fail[1] = (|(xc[31:0] & ~c.exit_ctl)) | (|(c.exit_ctl & ~xc[63:32]));
        ref_fail[0] = (|(nc[31:0] & ~c.entry_ctl)) | (|(c.entry_ctl & ~nc[63:32]));
    endfunction

    // One read: strobe for one edge, answer the cycle after
    task automatic rd(input logic [11:0] idx, input logic [63:0] exp, input logic err);
        @(posedge mclk_i);
        rd_en_i  <= 1'b1;
        rd_idx_i <= idx;
        @(posedge mclk_i);
        rd_en_i <= 1'b0;
        #1;
        check("rd_valid", {63'h0, rd_valid_o}, 64'h1);
        check("rd_err", {63'h0, rd_err_o}, {63'h0, err});
        check("rd_data", rd_data_o, exp);
    endtask

    // One entry check: verdict at once, causes and done one cycle later
    task automatic ent(input vcc_ctl_s c);
        logic [2:0] e;
        e = ref_fail(c);
        @(posedge mclk_i);
        chk_i <= 1'b1;
        ctl_i <= c;
        #1;
        check("fail", {63'h0, fail_o}, {63'h0, |e});
        @(posedge mclk_i);
        chk_i <= 1'b0;
        #1;
        check("done", {63'h0, done_o}, 64'h1);
        check("cause", {61'h0, cause_o}, {61'h0, e});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reads();
        rd(SEC_CAP_IDX, SEC_CAP_RST, 1'b0);
        check("sec_low", rd_data_o[31:0], 32'h0);
        rd(EXIT_CAP_IDX, EXIT_CAP_RST, 1'b0);
        check("exit_f1", rd_data_o[31:0] & EXIT_FORCED_ONE_MASK, EXIT_FORCED_ONE_MASK);
        rd(ENTRY_CAP_IDX, ENTRY_CAP_RST, 1'b0);
        check("entry_f1", rd_data_o[31:0] & ENTRY_FORCED_ONE_MASK, ENTRY_FORCED_ONE_MASK);
        rd(FULL_EXIT_CAP_IDX, FULL_EXIT_CAP_RST, 1'b0);
        rd(FULL_ENTRY_CAP_IDX, FULL_ENTRY_CAP_RST, 1'b0);
        rd(12'h485, 64'h0, 1'b0 | 1'b1);
        $display("test reads done");
    endtask

    // Writes must leave the constants untouched
    task automatic t_write();
        @(posedge mclk_i);
        wr_en_i   <= 1'b1;
        wr_data_i <= 64'hFFFF_FFFF_FFFF_FFFF;
        @(posedge mclk_i);
        wr_en_i  <= 1'b0;
        rd_en_i  <= 1'b1;
        rd_idx_i <= FULL_EXIT_CAP_IDX;
        @(posedge mclk_i);
        rd_en_i <= 1'b0;
        #1;
        check("rd_after_wr", rd_data_o, FULL_EXIT_CAP_RST);
        rd(EXIT_CAP_IDX, EXIT_CAP_RST, 1'b0);
        $display("test write done");
    endtask

    task automatic t_checks();
        vcc_ctl_s c;
        ent(base);
        c = base; c.secondary = 32'h0000_0100; ent(c);
        c.primary[SEC_GATE_CTL_BIT] = 1'b1; ent(c);
        c.secondary = 32'h0000_0001; ent(c);
        c = base; c.exit_ctl[2] = 1'b0; ent(c);
        c = base; c.exit_ctl[0] = 1'b0; ent(c);
        c = base; c.exit_ctl[22] = 1'b1; ent(c);
        c = base; c.entry_ctl[2] = 1'b0; ent(c);
        c = base; c.entry_ctl[0] = 1'b0; ent(c);
        c = base; c.entry_ctl[16] = 1'b1; ent(c);
        $display("test checks done");
    endtask

    // Verdict and end of run
    task automatic finish_test();
        $display("compares %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Watchdog; the whole run needs well under 10 us
    initial begin
        #100000;
        err_total++;
        finish_test();
    end

    initial begin
        rstn_i = 1'b0; rd_en_i = 1'b0; wr_en_i = 1'b0; chk_i = 1'b0;
        rd_idx_i = 12'h0; wr_data_i = 64'h0;
        base = '{primary: 32'h0, secondary: 32'h0, exit_ctl: FULL_EXIT_CAP_RST[31:0],
                 entry_ctl: FULL_ENTRY_CAP_RST[31:0]};
        ctl_i = base;
        repeat (10) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_reads();
        t_write();
        t_checks();
        finish_test();
    end
endmodule
